// file: src/rivm_pkg.sv
// Package for the reset and interrupt vector mapper.
// Assumes word-addressed program memory with 12-bit program counter.
package rivm_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned RIVM_PC_W   = 12;
   localparam int unsigned RIVM_NSRC   = 25;
   localparam int unsigned RIVM_SRC_W  = 5;

   // ------------------------------------------------------------
   // Addresses
   // ------------------------------------------------------------
   localparam logic [RIVM_PC_W-1:0] RIVM_APP_RESET_ADDR = 12'h000;
   localparam logic [RIVM_PC_W-1:0] RIVM_TABLE_OFFSET   = 12'h001;
   // Boot section start; depends on boot size fuses kept outside
   localparam logic [RIVM_PC_W-1:0] RIVM_BOOT_ADDR_RST  = 12'hC00;
   localparam logic [RIVM_PC_W-1:0] RIVM_FETCH_RST      = 12'h000;

   // Source index i (0..24) maps to base vector i + 1
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_EXT0      = 5'h00;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_EXT1      = 5'h01;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_PCH0      = 5'h02;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_PCH1      = 5'h03;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_PCH2      = 5'h04;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_WDOG      = 5'h05;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T2_CA     = 5'h06;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T2_CB     = 5'h07;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T2_OVF    = 5'h08;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T1_CAPT   = 5'h09;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T1_CA     = 5'h0A;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T1_CB     = 5'h0B;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T1_OVF    = 5'h0C;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T0_CA     = 5'h0D;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T0_CB     = 5'h0E;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_T0_OVF    = 5'h0F;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_SER_PER   = 5'h10;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_UART_RX   = 5'h11;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_TX_EMPTY  = 5'h12;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_UART_TX   = 5'h13;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_CONV      = 5'h14;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_NVDATA    = 5'h15;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_ACOMP     = 5'h16;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_TWO_WIRE  = 5'h17;
   localparam logic [RIVM_SRC_W-1:0] RIVM_SRC_STORE     = 5'h18;

   typedef enum logic [1:0] {RIVM_IDLE, RIVM_RESET_JUMP, RIVM_IRQ_JUMP} rivm_kind_t;

endpackage

// file: src/rivm_vector_mapper.sv
// Reset and interrupt vector address generator for the core fetch unit.
// Assumes the core pulses irq_accept for one cycle with a valid source index,
// and takes fetch_addr when fetch_load is high.
//
// What this block does
// - With the boot reset fuse unprogrammed, every reset starts fetch at address 0x000.
// - With the boot reset fuse programmed, every reset starts fetch at the boot-loader reset address.
// - With vector relocation set, each interrupt target is its base vector plus the boot section start.
// - The vector table starts at 0x001, or at boot address plus 0x001 when relocated, whatever the fuse.
// - External request 0 uses base 0x001 and external request 1 uses base 0x002.
// - Pin change requests 0, 1 and 2 use bases 0x003, 0x004 and 0x005.
// - Watchdog uses 0x006 and timer 2 compare A, compare B, overflow use 0x007 to 0x009.
// - Timer 1 capture, compare A, compare B and overflow use 0x00A to 0x00D.
// - Timer 0 compare A, compare B and overflow use 0x00E to 0x010.
// - Serial peripheral uses 0x011 and the USART receive, empty, transmit use 0x012 to 0x014.
// - Converter done uses 0x015, data memory ready 0x016, analog comparator 0x017.
// - Two-wire interface uses 0x018 and self-programming store done uses 0x019.
`timescale 1ns/10ps
module rivm_vector_mapper
   import rivm_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire logic                  boot_reset_fuse,
   input  wire logic                  vector_table_relocate,
   input  wire logic [RIVM_PC_W-1:0]  boot_start_addr,
   input  wire logic                  irq_accept,
   input  wire logic [RIVM_SRC_W-1:0] irq_source,
   output logic      [RIVM_PC_W-1:0]  fetch_addr,
   output logic                       fetch_load,
   output logic                       src_error
);

   // ------------------------------------------------------------
   // Vector table
   // ------------------------------------------------------------
   // Base of each source is one word past the previous slot
   logic [RIVM_PC_W-1:0] base_tbl [RIVM_NSRC];
   genvar gi;
   generate
      for (gi = 0; gi < RIVM_NSRC; gi++)
      begin : g_base
         assign base_tbl[gi] = RIVM_TABLE_OFFSET + RIVM_PC_W'(gi);
      end
   endgenerate

   // ------------------------------------------------------------
   // Address selection
   // ------------------------------------------------------------
   wire                  src_valid   = (irq_source < RIVM_SRC_W'(RIVM_NSRC));
   wire [RIVM_PC_W-1:0]  base_sel    = src_valid ? base_tbl[irq_source] : RIVM_TABLE_OFFSET;
   wire [RIVM_PC_W-1:0]  table_shift = vector_table_relocate ? boot_start_addr : RIVM_APP_RESET_ADDR;
   // Top carry dropped: a table placed at the end of flash wraps to zero
   wire [RIVM_PC_W-1:0]  irq_target  = base_sel + table_shift;
   // Fuse value 1 means unprogrammed
   wire [RIVM_PC_W-1:0]  reset_target = boot_reset_fuse ? RIVM_APP_RESET_ADDR : boot_start_addr;

   // ------------------------------------------------------------
   // Fetch redirect
   // ------------------------------------------------------------
   // Reset jump issued on the first cycle after release so the
   // fuse level is sampled clocked, not captured under reset.
   logic                 rst_pend_q;
   logic [RIVM_PC_W-1:0] addr_q;
   logic                 load_q;
   logic                 err_q;
   rivm_kind_t           kind_q;

   wire                  do_reset = rst_pend_q;
   // Accept during the reset jump is dropped; the core must ask again
   wire                  do_irq   = irq_accept && !rst_pend_q;
   wire [RIVM_PC_W-1:0]  addr_d   = do_reset ? reset_target : (do_irq ? irq_target : addr_q);
   rivm_kind_t           kind_d;
   assign kind_d = do_reset ? RIVM_RESET_JUMP : (do_irq ? RIVM_IRQ_JUMP : RIVM_IDLE);

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rst_pend_q <= 1'b1;
         addr_q     <= RIVM_FETCH_RST;
         load_q     <= 1'b0;
         err_q      <= 1'b0;
         kind_q     <= RIVM_IDLE;
      end
      else
      begin
         rst_pend_q <= 1'b0;
         addr_q     <= addr_d;
         load_q     <= do_reset || do_irq;
         err_q      <= do_irq && !src_valid;
         kind_q     <= kind_d;
      end
   end

   assign fetch_addr = addr_q;
   assign fetch_load = load_q;
   assign src_error  = err_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_reset_app_addr: assert property (@(posedge mclk) disable iff (srst)
      $fell(rst_pend_q) && $past(boot_reset_fuse) |-> fetch_load && fetch_addr == 12'h000)
      else $error("reset did not jump to zero");

   a_reset_boot_addr: assert property (@(posedge mclk) disable iff (srst)
      $fell(rst_pend_q) && !$past(boot_reset_fuse) |-> fetch_load && fetch_addr == $past(boot_start_addr))
      else $error("reset did not jump to boot address");

   a_irq_relocated: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && vector_table_relocate && irq_source < 5'h19
      |=> fetch_addr == $past(boot_start_addr) + 12'h001 + {7'h00, $past(irq_source)})
      else $error("relocated vector wrong");

   a_table_start: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_EXT0 && !vector_table_relocate
      |=> fetch_addr == 12'h001)
      else $error("table start not at one");

   a_ext_one: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_EXT1 && !vector_table_relocate
      |=> fetch_addr == 12'h002)
      else $error("external one vector wrong");

   a_pin_change: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_PCH0 && !vector_table_relocate
      |=> fetch_addr == 12'h003)
      else $error("pin change vector wrong");

   a_watchdog_vec: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_WDOG && !vector_table_relocate
      |=> fetch_addr == 12'h006)
      else $error("watchdog vector wrong");

   a_timer1_capt: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T1_CAPT && !vector_table_relocate
      |=> fetch_addr == 12'h00A)
      else $error("timer 1 capture vector wrong");

   a_timer0_ca: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T0_CA && !vector_table_relocate
      |=> fetch_addr == 12'h00E)
      else $error("timer 0 compare vector wrong");

   a_serial_per: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_SER_PER && !vector_table_relocate
      |=> fetch_addr == 12'h011)
      else $error("serial peripheral vector wrong");

   a_conv_done: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_CONV && !vector_table_relocate
      |=> fetch_addr == 12'h015)
      else $error("converter vector wrong");

   a_store_done: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_STORE && !vector_table_relocate
      |=> fetch_addr == 12'h019)
      else $error("store done vector wrong");

   a_load_pulse: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q ##1 !irq_accept |=> !fetch_load)
      else $error("fetch load not a single pulse");

   // ------------------------------------------------------------
   // Checks: remaining table slots
   // ------------------------------------------------------------
   a_pin_change_one: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_PCH1 && !vector_table_relocate
      |=> fetch_addr == 12'h004)
      else $error("pin change one vector wrong");

   a_pin_change_two: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_PCH2 && !vector_table_relocate
      |=> fetch_addr == 12'h005)
      else $error("pin change two vector wrong");

   a_timer2_cb: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T2_CB && !vector_table_relocate
      |=> fetch_addr == 12'h008)
      else $error("timer 2 compare B vector wrong");

   a_timer2_ovf: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T2_OVF && !vector_table_relocate
      |=> fetch_addr == 12'h009)
      else $error("timer 2 overflow vector wrong");

   a_timer1_ca: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T1_CA && !vector_table_relocate
      |=> fetch_addr == 12'h00B)
      else $error("timer 1 compare A vector wrong");

   a_timer1_cb: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T1_CB && !vector_table_relocate
      |=> fetch_addr == 12'h00C)
      else $error("timer 1 compare B vector wrong");

   a_timer1_ovf: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T1_OVF && !vector_table_relocate
      |=> fetch_addr == 12'h00D)
      else $error("timer 1 overflow vector wrong");

   a_timer0_cb: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T0_CB && !vector_table_relocate
      |=> fetch_addr == 12'h00F)
      else $error("timer 0 compare B vector wrong");

   a_timer0_ovf: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_T0_OVF && !vector_table_relocate
      |=> fetch_addr == 12'h010)
      else $error("timer 0 overflow vector wrong");

   a_uart_receive: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_UART_RX && !vector_table_relocate
      |=> fetch_addr == 12'h012)
      else $error("receive complete vector wrong");

   a_uart_empty: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_TX_EMPTY && !vector_table_relocate
      |=> fetch_addr == 12'h013)
      else $error("data register empty vector wrong");

   a_uart_transmit: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_UART_TX && !vector_table_relocate
      |=> fetch_addr == 12'h014)
      else $error("transmit complete vector wrong");

   a_nvdata_ready: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_NVDATA && !vector_table_relocate
      |=> fetch_addr == 12'h016)
      else $error("data memory ready vector wrong");

   a_analog_comp: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_ACOMP && !vector_table_relocate
      |=> fetch_addr == 12'h017)
      else $error("analog comparator vector wrong");

   a_two_wire: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_TWO_WIRE && !vector_table_relocate
      |=> fetch_addr == 12'h018)
      else $error("two-wire vector wrong");

   a_reloc_start: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_EXT0 && vector_table_relocate
      |=> fetch_addr == $past(boot_start_addr) + 12'h001)
      else $error("relocated table start wrong");

   a_reloc_pin: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_PCH0 && vector_table_relocate
      |=> fetch_addr == $past(boot_start_addr) + 12'h003)
      else $error("relocated pin change vector wrong");

   a_reloc_last: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source == RIVM_SRC_STORE && vector_table_relocate
      |=> fetch_addr == $past(boot_start_addr) + 12'h019)
      else $error("relocated last vector wrong");

   a_app_table: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && !vector_table_relocate && irq_source < 5'h19
      |=> fetch_addr == 12'h001 + {7'h00, $past(irq_source)})
      else $error("application table vector wrong");

   // ------------------------------------------------------------
   // Checks: reset jump and fetch handshake
   // ------------------------------------------------------------
   a_reset_outputs: assert property (@(posedge mclk)
      srst
      |=> !fetch_load && !src_error && fetch_addr == RIVM_FETCH_RST)
      else $error("outputs not cleared by reset");

   a_drop_accept: assert property (@(posedge mclk) disable iff (srst)
      rst_pend_q && irq_accept
      |=> kind_q == RIVM_RESET_JUMP && !src_error)
      else $error("accept in release cycle not dropped");

   a_reset_single: assert property (@(posedge mclk) disable iff (srst)
      $fell(rst_pend_q) && !irq_accept
      |=> !fetch_load)
      else $error("reset jump not a single pulse");

   a_src_error: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source > 5'h18
      |=> src_error && fetch_addr == ($past(vector_table_relocate) ? $past(boot_start_addr) : 12'h000) + 12'h001)
      else $error("out of range source not flagged");

   a_src_quiet: assert property (@(posedge mclk) disable iff (srst)
      irq_accept && !rst_pend_q && irq_source < 5'h19
      |=> !src_error)
      else $error("valid source flagged as error");

   a_no_spurious: assert property (@(posedge mclk) disable iff (srst)
      !irq_accept && !rst_pend_q
      |=> !fetch_load)
      else $error("fetch load without a request");

   a_fetch_hold: assert property (@(posedge mclk) disable iff (srst)
      !fetch_load && !$past(srst)
      |-> $stable(fetch_addr))
      else $error("fetch address moved without a load");

   a_kind_load: assert property (@(posedge mclk) disable iff (srst)
      fetch_load == (kind_q != RIVM_IDLE))
      else $error("jump kind disagrees with fetch load");

endmodule // rivm_vector_mapper

// file: tb/rivm_core_model.sv
// Fetch side model: keeps the last loaded target and counts loads.
// Assumes fetch_load is a one-cycle pulse on mclk.
`timescale 1ns/10ps
module rivm_core_model
   import rivm_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic [RIVM_PC_W-1:0] fetch_addr,
   input  wire logic                 fetch_load,
   output logic      [RIVM_PC_W-1:0] last_target,
   output int                        load_count
);
   int n_loads = 0;
   assign load_count = n_loads;
   // Counts edges, so a stretched pulse shows as extra loads
   always @(posedge mclk)
   begin
      if (fetch_load === 1'b1)
      begin
         last_target <= fetch_addr;
         n_loads     <= n_loads + 1;
      end
   end
endmodule // rivm_core_model

// file: tb/tb_reset_irq_vector_mapper.sv
// Self-checking bench for the vector mapper.
// Assumes inputs are driven on falling edges, results one cycle later.
`timescale 1ns/10ps
module tb_reset_irq_vector_mapper;
   import rivm_pkg::*;
   typedef struct {logic rel; logic [4:0] src; logic [11:0] exp; logic err;} rivm_row_t;
   logic        mclk = 0, srst = 1, boot_reset_fuse = 1, vector_table_relocate = 0, irq_accept = 0;
   logic [11:0] boot_start_addr = 12'hC00;
   logic [4:0]  irq_source = 5'h00;
   logic [11:0] fetch_addr, last_target;
   logic        fetch_load, src_error;
   int          load_count, n_exp = 0, miscompares = 0, total_checks = 0;
   rivm_row_t   rows [51];
   rivm_vector_mapper i_rivm_vector_mapper (.mclk(mclk), .srst(srst), .boot_reset_fuse(boot_reset_fuse),
      .vector_table_relocate(vector_table_relocate), .boot_start_addr(boot_start_addr),
      .irq_accept(irq_accept), .irq_source(irq_source), .fetch_addr(fetch_addr),
      .fetch_load(fetch_load), .src_error(src_error));
   rivm_core_model i_rivm_core_model (.mclk(mclk), .fetch_addr(fetch_addr), .fetch_load(fetch_load),
      .last_target(last_target), .load_count(load_count));
   initial forever #4 mclk = ~mclk;
   task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      if (miscompares == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // An accept in the release cycle must be dropped, not vectored
   task automatic reset_run(input logic fuse, input logic [11:0] exp);
      int n;
      srst = 1;
      boot_reset_fuse = fuse;
      repeat (2) @(negedge mclk);
      srst = 0;
      irq_accept = 1;
      @(negedge mclk);
      irq_accept = 0;
      n = 0;
      while (fetch_load !== 1'b1 && n < 4)
      begin
         @(negedge mclk);
         n++;
      end
      if (n == 4)
      begin
         miscompares++;
         close_out();
      end
      chk("reset target", fetch_addr, exp);
      chk("reset latency", 12'(n), 12'h000);
      n_exp++;
      @(negedge mclk);
      chk("dropped accept", {11'h000, fetch_load}, 12'h000);
   endtask
   task automatic do_irq(input rivm_row_t r);
      vector_table_relocate = r.rel;
      irq_accept = 1;
      irq_source = r.src;
      @(negedge mclk);
      chk("load", {11'h000, fetch_load}, 12'h001);
      chk("target", fetch_addr, r.exp);
      chk("src error", {11'h000, src_error}, {11'h000, r.err});
      n_exp++;
   endtask
   initial
   begin
      for (int i = 0; i < 50; i++)
         rows[i] = '{i >= 25, 5'(i % 25), 12'(i % 25 + 1) + (i >= 25 ? 12'hC00 : 12'h000), 1'b0};
      rows[50] = '{1'b0, 5'h19, 12'h001, 1'b1};
      reset_run(1'b1, 12'h000);
      // Back to back accepts, one per cycle
      foreach (rows[i])
         do_irq(rows[i]);
      irq_accept = 0;
      @(negedge mclk);
      chk("load end", {11'h000, fetch_load}, 12'h000);
      boot_start_addr = 12'h800;
      reset_run(1'b0, 12'h800);
      do_irq('{1'b1, 5'h18, 12'h819, 1'b0});
      do_irq('{1'b0, 5'h01, 12'h002, 1'b0});
      irq_accept = 0;
      reset_run(1'b1, 12'h000);
      do_irq('{1'b1, 5'h00, 12'h801, 1'b0});
      irq_accept = 0;
      @(negedge mclk);
      chk("model target", last_target, 12'h801);
      chk("load count", 12'(load_count), 12'(n_exp));
      close_out();
   end
endmodule // tb_reset_irq_vector_mapper
